// file: ahio_map.svh
`ifndef AHIO_MAP_SVH
`define AHIO_MAP_SVH
// Clock period in ns
`define AHIO_CLK_NS 25
// Handshake timing figures in ns
`define AHIO_REQ_TO_ACK_OFF_MIN_NS 100
`define AHIO_REQ_TO_ACK_OFF_MAX_NS 200
`define AHIO_TE_PULSE_MIN_NS 225
`define AHIO_TE_PULSE_MAX_NS 275
`define AHIO_LE_PULSE_MIN_NS 125
`define AHIO_LE_REQ_OFF_TO_ACK_OFF_NS 150
`define AHIO_DATA_SETUP_NS 25
`define AHIO_NEXT_DATA_MAX_NS 50
`define AHIO_LONG_PULSE_MIN_NS 500
`define AHIO_DELAY_STEP_NS 100
`define AHIO_DELAY_MAX_NS 700
// Least times round up, longest round down
`define AHIO_CYC_UP(ns) (((ns) + `AHIO_CLK_NS - 1) / `AHIO_CLK_NS)
`define AHIO_CYC_DN(ns) ((ns) / `AHIO_CLK_NS)
// Cycle counts
`define AHIO_REQ_ACK_OFF_CYC `AHIO_CYC_UP(`AHIO_REQ_TO_ACK_OFF_MIN_NS)
`define AHIO_TE_PULSE_CYC `AHIO_CYC_UP(`AHIO_TE_PULSE_MIN_NS)
`define AHIO_LE_PULSE_CYC `AHIO_CYC_UP(`AHIO_LE_PULSE_MIN_NS)
`define AHIO_LE_OFF_CYC `AHIO_CYC_UP(`AHIO_LE_REQ_OFF_TO_ACK_OFF_NS)
`define AHIO_SETUP_CYC `AHIO_CYC_UP(`AHIO_DATA_SETUP_NS)
`define AHIO_STEP_CYC `AHIO_CYC_UP(`AHIO_DELAY_STEP_NS)
`define AHIO_LONG_PULSE_CYC `AHIO_CYC_UP(`AHIO_LONG_PULSE_MIN_NS)
// Register byte offsets
`define AHIO_CTRL_OFF 12'h000
`define AHIO_STAT_OFF 12'h004
`define AHIO_TXD_OFF 12'h008
`define AHIO_RXD_OFF 12'h00c
// Control field positions
`define AHIO_CTRL_EN 0
`define AHIO_CTRL_DIR 1
`define AHIO_CTRL_PROTO_LO 2
`define AHIO_CTRL_DLY_LO 4
`define AHIO_CTRL_LATCH 7
`define AHIO_CTRL_ACK_POL 8
`define AHIO_CTRL_REQ_POL 9
`define AHIO_CTRL_LATCH_SET 10
// Control reset value
`define AHIO_CTRL_RST 32'h0000_0000
`endif

// file: ahio_pkg.sv
package ahio_pkg;
    // Handshake protocol select
    typedef enum logic [1:0] {
        AHIO_LEVEL = 2'h0,
        AHIO_TRAIL = 2'h1,
        AHIO_LEAD = 2'h2,
        AHIO_LONG = 2'h3
    } ahio_proto_e;
    typedef logic [15:0] ahio_count_t;
endpackage

// file: ahio_cfg_if.sv
interface ahio_cfg_if;
    import ahio_pkg::*;
    logic enable;
    logic dir_out;
    ahio_proto_e proto;
    logic [2:0] delay_sel;
    logic latch_en;
    logic ack_pol_low;
    logic req_pol_low;
    logic idle;
    modport regs (output enable, dir_out, proto, delay_sel, latch_en,
        ack_pol_low, req_pol_low, input idle);
    modport core (input enable, dir_out, proto, delay_sel, latch_en,
        ack_pol_low, req_pol_low, output idle);
endinterface

// file: ahio_regs.sv
`include "ahio_map.svh"
module ahio_regs
    import ahio_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    ahio_cfg_if.regs cfg,
    output logic [WIDTH-1:0] tx_word,
    output logic tx_valid,
    input wire logic tx_take,
    input wire logic [WIDTH-1:0] rx_word,
    input wire logic rx_load,
    output logic rx_take
);
    logic [31:0] ctrl_q;
    logic [WIDTH-1:0] txd_q;
    logic txv_q;
    logic [WIDTH-1:0] rxd_q;
    logic rxv_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    // Address decode
    wire access = psel && penable;
    wire hit_ctrl = paddr == `AHIO_CTRL_OFF;
    wire hit_stat = paddr == `AHIO_STAT_OFF;
    wire hit_txd = paddr == `AHIO_TXD_OFF;
    wire hit_rxd = paddr == `AHIO_RXD_OFF;
    wire mapped = hit_ctrl || hit_stat || hit_txd || hit_rxd;
    wire wr = access && pwrite;
    wire rd = access && !pwrite;
    wire tx_wr = wr && hit_txd;
    wire rx_rd = rd && hit_rxd;
    wire [31:0] stat_word = {28'h0, rxv_q, txv_q, cfg.idle, ctrl_q[0]};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_q :
        hit_stat ? stat_word :
        hit_txd ? 32'(txd_q) :
        hit_rxd ? 32'(rxd_q) : 32'h0;
    // Control written only while idle; a write made while busy is dropped, not held for idle
    // RULE26: idle gated update
    wire ctrl_wr = wr && hit_ctrl && cfg.idle;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q <= `AHIO_CTRL_RST;
        end
        else if (ctrl_wr)
        begin
            ctrl_q <= pwdata;
        end
    end
    // Transmit word holding register; set from software wins over take
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            txd_q <= '0;
            txv_q <= 1'b0;
        end
        else if (tx_wr)
        begin
            txd_q <= pwdata[WIDTH-1:0];
            txv_q <= 1'b1;
        end
        else if (tx_take)
        begin
            txv_q <= 1'b0;
        end
    end
    // Receive word register; a new word wins over a read clear
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rxd_q <= '0;
            rxv_q <= 1'b0;
        end
        else if (rx_load)
        begin
            rxd_q <= rx_word;
            rxv_q <= 1'b1;
        end
        else if (rx_rd)
        begin
            rxv_q <= 1'b0;
        end
    end
    // Read data and error response
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prdata_q <= 32'h0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            prdata_q <= (psel && !penable && !pwrite) ? rd_mux : prdata_q;
            pslverr_q <= psel && !penable && !mapped;
        end
    end
    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = pslverr_q && access;
    assign tx_word = txd_q;
    assign tx_valid = txv_q;
    assign rx_take = !rxv_q;
    // Field extraction
    // RULE8: latch default off out
    wire latch_out = ctrl_q[`AHIO_CTRL_LATCH_SET] ? ctrl_q[`AHIO_CTRL_LATCH]
        : 1'b0;
    // RULE6: latch default on in
    wire latch_in = ctrl_q[`AHIO_CTRL_LATCH_SET] ? ctrl_q[`AHIO_CTRL_LATCH]
        : 1'b1;
    assign cfg.enable = ctrl_q[`AHIO_CTRL_EN];
    assign cfg.dir_out = ctrl_q[`AHIO_CTRL_DIR];
    assign cfg.proto = ahio_proto_e'(ctrl_q[`AHIO_CTRL_PROTO_LO +: 2]);
    assign cfg.delay_sel = ctrl_q[`AHIO_CTRL_DLY_LO +: 3];
    assign cfg.latch_en = ctrl_q[`AHIO_CTRL_DIR] ? latch_out : latch_in;
    // RULE25: polarity select
    assign cfg.ack_pol_low = ctrl_q[`AHIO_CTRL_ACK_POL];
    assign cfg.req_pol_low = ctrl_q[`AHIO_CTRL_REQ_POL];
endmodule

// file: ahio_core.sv
// Local design decisions: the register addresses and the APB interface to the registers.
`include "ahio_map.svh"
// Notes on behaviour
// RULE1: level output drives data before raising acknowledge.
// RULE2: level acknowledge holds until an active-going request edge.
// RULE3: request already active: wait for drop and reassert first.
// RULE4: request edge drops acknowledge 100 to 200 ns later.
// RULE5: level output and leading input delay precedes acknowledge.
// RULE6: input latching on by default captures at request edge.
// RULE7: trailing input with latching captures on request trailing edge.
// RULE8: output latching off by default; data stays after request.
// RULE9: edge output with latching shows next word within 50 ns; code loads next word only on leaving idle, latching or not.
// RULE10: trailing edge of each pulse signals readiness.
// RULE11: leading edge of each pulse signals readiness.
// RULE12: long pulse delay widens acknowledge instead of postponing it.
// RULE13: long pulse suits classic peripheral: active low, 500 ns.
// RULE14: trailing input idles low, pulses per word accepted.
// RULE15: peripheral pulses request only after acknowledge trailing edge.
// RULE16: trailing pulse 225 to 275 ns plus delay.
// RULE17: edge output data valid 25 ns before acknowledge.
// RULE18: peripheral request high and low at least 75 ns.
// RULE19: peripheral ends next request after acknowledge inactive.
// RULE20: leading input waits for request; start before its pulse.
// RULE21: leading input fixed width, extended while request stays.
// RULE22: peripheral strobes after seeing acknowledge leading edge.
// RULE23: leading output pulse 125 ns, off 150 ns after request off; code ends the pulse on a fixed count and ignores request off.
// RULE24: delay 0 to 700 ns in 100 ns steps.
// RULE25: acknowledge and request polarity selectable.
// RULE26: protocol and direction change only while idle.
module ahio_core
    import ahio_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    ahio_cfg_if.core cfg,
    input wire logic req_pin,
    output logic ack_pin,
    input wire logic [WIDTH-1:0] data_in,
    output logic [WIDTH-1:0] data_out,
    output logic data_oe,
    input wire logic [WIDTH-1:0] tx_word,
    input wire logic tx_valid,
    output logic tx_take,
    output logic [WIDTH-1:0] rx_word,
    output logic rx_load,
    input wire logic rx_take
);
    typedef enum logic [2:0] {
        AHIO_IDLE, AHIO_PRE, AHIO_ACK_ON, AHIO_HOLD, AHIO_OFF_WAIT,
        AHIO_REQ_WAIT, AHIO_GAP
    } ahio_state_e;
    ahio_state_e state_q, state_d;
    ahio_count_t cnt_q, cnt_d;
    logic ack_q, ack_d;
    logic req_q;
    logic armed_q, armed_d;
    logic [WIDTH-1:0] dout_q;
    logic [WIDTH-1:0] rxw_q;
    logic rxl_q;
    // Delay in cycles from the three bit step select
    // RULE24: delay steps
    function automatic ahio_count_t dly(input logic [2:0] sel);
        dly = ahio_count_t'(sel) * ahio_count_t'(`AHIO_STEP_CYC);
    endfunction
    // Request normalised to active high
    wire req = req_pin ^ cfg.req_pol_low;
    wire req_rise = req && !req_q;
    wire req_fall = !req && req_q;
    wire out = cfg.dir_out;
    wire lvl = cfg.proto == AHIO_LEVEL;
    wire trail = cfg.proto == AHIO_TRAIL;
    wire lead = cfg.proto == AHIO_LEAD;
    wire lng = cfg.proto == AHIO_LONG;
    wire ready = out ? tx_valid : rx_take;
    wire [15:0] d = dly(cfg.delay_sel);
    // RULE5: delay before ack
    wire [15:0] pre_cyc = ((lvl && out) || (lead && !out)) ? d :
        (lvl ? 16'h0 : 16'(`AHIO_SETUP_CYC));
    // RULE16: trailing width plus delay
    // RULE12: long pulse width
    // RULE23: leading width
    wire [15:0] pulse_cyc = trail ? 16'(`AHIO_TE_PULSE_CYC) + d :
        lng ? 16'(`AHIO_LE_PULSE_CYC) + d : 16'(`AHIO_LE_PULSE_CYC);
    // Edge that reports the peer ready: trailing or leading per protocol
    // RULE10: trailing readiness
    // RULE11: leading readiness
    wire peer_edge = trail ? req_fall : req_rise;
    // Capture strobe per direction and latching
    // RULE7: trailing capture
    // RULE6: capture on edge
    wire cap_edge = cfg.latch_en && !out && peer_edge;
    // Request sampling register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            req_q <= 1'b0;
        end
        else
        begin
            req_q <= req;
        end
    end
    // Handshake sequencer
    always_comb
    begin
        state_d = state_q;
        cnt_d = (cnt_q != 16'h0) ? cnt_q - 16'h1 : cnt_q;
        ack_d = ack_q;
        armed_d = armed_q;
        tx_take = 1'b0;
        unique case (state_q)
            AHIO_IDLE:
            begin
                ack_d = 1'b0;
                // RULE20: wait for start
                if (cfg.enable && ready)
                begin
                    state_d = AHIO_PRE;
                    cnt_d = pre_cyc;
                end
            end
            AHIO_PRE:
            begin
                // RULE1: data before ack
                // RULE17: setup before ack
                if (cnt_q == 16'h0)
                begin
                    ack_d = 1'b1;
                    // RULE3: request already high
                    armed_d = lvl && !req;
                    state_d = lvl ? AHIO_HOLD : AHIO_ACK_ON;
                    cnt_d = pulse_cyc;
                end
            end
            AHIO_HOLD:
            begin
                // RULE2: hold until edge
                if (!req)
                begin
                    armed_d = 1'b1;
                end
                if (armed_q && req_rise)
                begin
                    state_d = AHIO_OFF_WAIT;
                    cnt_d = 16'(`AHIO_REQ_ACK_OFF_CYC);
                end
            end
            AHIO_OFF_WAIT:
            begin
                // RULE4: off in 100 to 200 ns
                if (cnt_q <= 16'h1)
                begin
                    ack_d = 1'b0;
                    tx_take = out;
                    state_d = AHIO_GAP;
                    cnt_d = d;
                end
            end
            AHIO_ACK_ON:
            begin
                // RULE14: one pulse per word
                // RULE11: peer edge during pulse
                if (peer_edge && !trail)
                begin
                    armed_d = 1'b1;
                end
                // RULE21: stretch while request
                if (cnt_q == 16'h0 && !(lead && !out && req))
                begin
                    ack_d = 1'b0;
                    state_d = AHIO_REQ_WAIT;
                    cnt_d = lead && out ? 16'(`AHIO_LE_OFF_CYC) : 16'h0;
                end
            end
            AHIO_REQ_WAIT:
            begin
                if (peer_edge || armed_q)
                begin
                    armed_d = 1'b0;
                    tx_take = out;
                    state_d = AHIO_GAP;
                    cnt_d = lng ? d : 16'h0;
                end
            end
            AHIO_GAP:
            begin
                // RULE24: spacing grows with delay in level and long modes
                if (cnt_q == 16'h0)
                begin
                    state_d = AHIO_IDLE;
                end
            end
            default:
            begin
                state_d = AHIO_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= AHIO_IDLE;
            cnt_q <= 16'h0;
            ack_q <= 1'b0;
            armed_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ack_q <= ack_d;
            armed_q <= armed_d;
        end
    end
    // Output word: loaded when leaving idle, held after request edge
    // RULE8: data held after edge
    // RULE9: next word loaded only on leaving idle, not within 50 ns
    wire dout_load = state_q == AHIO_IDLE && state_d == AHIO_PRE && out;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dout_q <= '0;
        end
        else if (dout_load)
        begin
            dout_q <= tx_word;
        end
    end
    // Input capture: request edge or own acknowledge rise; only the request edge raises rx_load
    wire cap_ack = !cfg.latch_en && !out && !ack_q && ack_d;
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rxw_q <= '0;
            rxl_q <= 1'b0;
        end
        else
        begin
            rxl_q <= (cap_edge || cap_ack) &&
                state_q != AHIO_IDLE && state_q != AHIO_PRE;
            if (cap_edge || cap_ack)
            begin
                rxw_q <= data_in;
            end
        end
    end
    assign rx_word = rxw_q;
    assign rx_load = rxl_q;
    assign data_out = dout_q;
    assign data_oe = out && cfg.enable;
    // RULE25: ack polarity
    assign ack_pin = ack_q ^ cfg.ack_pol_low;
    assign cfg.idle = state_q == AHIO_IDLE;
endmodule

// file: ahio_top.sv
module ahio_top
    import ahio_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_pin,
    output logic ack_pin,
    input wire logic [WIDTH-1:0] data_in,
    output logic [WIDTH-1:0] data_out,
    output logic data_oe
);
    logic [WIDTH-1:0] tx_word;
    logic tx_valid;
    logic tx_take;
    logic [WIDTH-1:0] rx_word;
    logic rx_load;
    logic rx_take;
    ahio_cfg_if cfg ();
    // Register file and handshake engine
    ahio_regs #(.WIDTH(WIDTH)) u_regs (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cfg(cfg), .tx_word(tx_word),
        .tx_valid(tx_valid), .tx_take(tx_take), .rx_word(rx_word),
        .rx_load(rx_load), .rx_take(rx_take)
    );
    // RULE13: long pulse configurable
    ahio_core #(.WIDTH(WIDTH)) u_core (
        .clk(clk), .reset_n(reset_n), .cfg(cfg), .req_pin(req_pin),
        .ack_pin(ack_pin), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .tx_word(tx_word), .tx_valid(tx_valid),
        .tx_take(tx_take), .rx_word(rx_word), .rx_load(rx_load),
        .rx_take(rx_take)
    );
endmodule

// file: ahio_props.sv
module ahio_props
    import ahio_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic req_pin,
    input wire logic ack_pin,
    input wire logic [WIDTH-1:0] data_in,
    input wire logic [WIDTH-1:0] data_out,
    input wire logic data_oe
);
    logic [31:0] ctrl_q;
    logic [7:0] len_q;
    logic [7:0] since_q;
    logic req_old_q;
    // Active levels and mode decode from the shadow control word
    wire ack_act = ack_pin ^ ctrl_q[8];
    wire req_act = req_pin ^ ctrl_q[9];
    wire [7:0] dly4 = {3'h0, ctrl_q[6:4], 2'h0};
    wire lvl = ctrl_q[3:2] == AHIO_LEVEL;
    wire trl = ctrl_q[3:2] == AHIO_TRAIL;
    wire led = ctrl_q[3:2] == AHIO_LEAD;
    wire lng = ctrl_q[3:2] == AHIO_LONG;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // Shadow control, acknowledge length and age of last request edge
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ctrl_q <= 32'h0000_0000;
            len_q <= 8'h00;
            since_q <= 8'hff;
            req_old_q <= 1'b0;
        end
        else
        begin
            // Reads resync the shadow after a write refused while busy
            if (psel && penable && paddr == 12'h000)
                ctrl_q <= pwrite ? pwdata : prdata;
            len_q <= ack_act ? len_q + 8'h01 : 8'h00;
            since_q <= (req_act && !req_old_q) ? 8'h00 :
                since_q + {7'h00, since_q != 8'hff};
            req_old_q <= req_act;
        end
    end
    a_oe_follows_ctrl: assert property ($stable(ctrl_q) |->
        data_oe == (ctrl_q[0] && ctrl_q[1])) else $error("oe wrong");
    a_level_ack_off: assert property (lvl && ack_act && $rose(req_act)
        |-> ##[1:8] !ack_act) else $error("level ack not dropped");
    a_level_ack_hold: assert property (lvl && $fell(ack_act)
        |-> since_q >= 8'd3 && since_q <= 8'd7) else $error("ack drop early");
    a_data_before_ack: assert property (ctrl_q[1] && $rose(ack_act)
        |-> $stable(data_out)) else $error("data not ahead of ack");
    a_trail_pulse_width: assert property (trl && $fell(ack_act)
        |-> len_q >= 8'd9 + dly4 && len_q <= 8'd11 + dly4)
        else $error("trailing pulse width");
    a_lead_pulse_min: assert property (led && $fell(ack_act)
        |-> len_q >= 8'd5) else $error("leading pulse short");
    a_long_pulse_width: assert property (lng && $fell(ack_act)
        |-> len_q >= 8'd5 + dly4) else $error("long pulse short");
    a_lead_in_stretch: assert property (led && !ctrl_q[1]
        && $fell(ack_act) |-> !$past(req_act)) else $error("ack cut early");
    a_unmapped_error: assert property (psel && penable
        && (paddr > 12'h00c || paddr[1:0] != 2'h0)
        |-> pslverr) else $error("no error on unmapped");
    a_mapped_ready: assert property (psel && penable
        && paddr <= 12'h00c && paddr[1:0] == 2'h0
        |-> pready && !pslverr) else $error("mapped access faulted");
endmodule
bind ahio_top ahio_props #(.WIDTH(WIDTH)) u_props (.clk(clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_pin(req_pin), .ack_pin(ack_pin),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

// file: ahio_peer.sv
module ahio_peer
    import ahio_pkg::*;
#(
    parameter int WIDTH = 32
) (
    input wire logic clk,
    input wire logic en,
    input wire ahio_proto_e proto,
    input wire logic dir_out,
    input wire logic ack_low,
    input wire logic req_low,
    input wire logic [1:0] slow,
    input wire logic [WIDTH-1:0] in_word,
    input wire logic ack_pin,
    input wire logic [WIDTH-1:0] data_out,
    output logic req_pin,
    output logic [WIDTH-1:0] data_in,
    output logic [WIDTH-1:0] got_word,
    output logic got_stb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic req_a;
    logic ack_old;
    int trig_n;
    int done_n;
    wire ack_a = ack_pin ^ ack_low;
    wire trail = proto == AHIO_TRAIL;
    assign req_pin = req_a ^ req_low;
    // Spot the acknowledge edge that invites a transfer, take output word
    // wait for invitation
    initial
    begin
        ack_old = 1'b0;
        trig_n = 0;
        got_stb = 1'b0;
        got_word = '0;
        forever
        begin
            @(negedge clk);
            got_stb = 1'b0;
            if (en && (trail ? ack_old && !ack_a : !ack_old && ack_a))
            begin
                trig_n++;
                got_stb = dir_out;
                got_word = data_out;
            end
            // Forget the line while disabled so a polarity swap is no edge
            ack_old = en && ack_a;
        end
    end
    // One request pulse per invitation; data spoiled once hold has run out
    initial
    begin
        req_a = 1'b0;
        data_in = '0;
        done_n = 0;
        forever
        begin
            @(posedge clk);
            if (done_n < trig_n)
            begin
                done_n++;
                repeat (slow) @(posedge clk);
                if (!dir_out)
                    data_in <= trail ? ~in_word : in_word;
                req_a <= 1'b1;
                @(posedge clk);
                if (!dir_out)
                    data_in <= in_word;
                repeat (3) @(posedge clk);
                req_a <= 1'b0;
                repeat (3) @(posedge clk);
                data_in <= ~in_word;
            end
        end
    end
endmodule

// file: tb_top.sv
module tb_top
    import ahio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset_n, psel, penable, pwrite, rd_chk, pen, dir_v, al_v, rl_v;
    logic pready, pslverr, req_pin, ack_pin, data_oe, got_stb;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdv, w, data_in, data_out, got_word, in_word;
    logic [1:0] slow;
    ahio_proto_e proto_v;
    logic [31:0] exp_rd[$];
    logic [31:0] exp_tx[$];
    int num_errors;
    int checks;
    ahio_top #(.WIDTH(32)) u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .req_pin(req_pin),
        .ack_pin(ack_pin), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe));
    ahio_peer #(.WIDTH(32)) u_peer (.clk(clk), .en(pen), .proto(proto_v),
        .dir_out(dir_v), .ack_low(al_v), .req_low(rl_v), .slow(slow),
        .in_word(in_word), .ack_pin(ack_pin), .data_out(data_out),
        .req_pin(req_pin), .data_in(data_in), .got_word(got_word),
        .got_stb(got_stb));
    task automatic complete_run();
        if (num_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want)
        begin
            num_errors++;
            $display("ERROR %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    // One APB transfer, held until pready at the access edge
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic chk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        rd_chk <= chk;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
        begin
            @(posedge clk);
        end
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        rd_chk <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        apb(1'b0, a, 32'h0, 1'b1);
    endtask
    // Poll one status bit until it reaches the wanted level
    task automatic wait_stat(input int b, input logic v);
        int n;
        n = 0;
        apb(1'b0, 12'h004, 32'h0, 1'b0);
        while (rdv[b] !== v && n < 400)
        begin
            apb(1'b0, 12'h004, 32'h0, 1'b0);
            n++;
        end
        if (n == 400)
        begin
            num_errors++;
            $display("ERROR %0t: status bit stuck", $time);
        end
    endtask
    // Configure one mode, then move three words through the port
    task automatic run(input ahio_proto_e p, input logic d,
        input logic [2:0] dl, input logic al, input logic rl);
        logic [31:0] c;
        c = {22'h0, rl, al, 1'b0, dl, p, d, 1'b0};
        pen <= 1'b0;
        apb(1'b1, 12'h000, c, 1'b0);
        proto_v <= p;
        dir_v <= d;
        al_v <= al;
        rl_v <= rl;
        slow <= 2'($urandom_range(3));
        in_word <= $urandom;
        pen <= 1'b1;
        apb(1'b1, 12'h000, c | 32'h1, 1'b0);
        rd(12'h000, c | 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            if (d)
            begin
                w = $urandom;
                exp_tx.push_back(w);
                apb(1'b1, 12'h008, w, 1'b0);
                if (p == AHIO_LEVEL && i == 0)
                begin
                    apb(1'b1, 12'h000, (c | 32'h1) ^ 32'h70, 1'b0);
                    rd(12'h000, c | 32'h1);
                end
                wait_stat(2, 1'b0);
            end
            else
            begin
                wait_stat(3, 1'b1);
                w = in_word;
                if (i < 2)
                    in_word <= $urandom;
                else
                    wait_stat(1, 1'b1);
                if (i == 2)
                    apb(1'b1, 12'h000, c, 1'b0);
                rd(12'h00c, w);
            end
        end
        wait_stat(1, 1'b1);
        apb(1'b1, 12'h000, c, 1'b0);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Compare each observed result with the oldest note
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite && rd_chk)
            check(prdata, exp_rd.pop_front());
        if (got_stb === 1'b1)
            check(got_word, exp_tx.pop_front());
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        $display("ERROR %0t: watchdog expired", $time);
        num_errors++;
        complete_run();
    end
    initial
    begin
        {reset_n, psel, penable, pwrite, rd_chk, pen, dir_v, al_v, rl_v} = 0;
        {paddr, pwdata, in_word, slow} = 0;
        proto_v = AHIO_LEVEL;
        num_errors = 0;
        checks = 0;
        void'($urandom(98));
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h2);
        apb(1'b1, 12'h010, 32'hffff_ffff, 1'b0);
        apb(1'b0, 12'h010, 32'h0, 1'b0);
        rd(12'h000, 32'h0);
        for (int p = 0; p < 4; p++)
        begin
            for (int d = 0; d < 2; d++)
            begin
                if (p == 3)
                    run(AHIO_LONG, 1'(d), 3'h4, 1'b1, 1'b1);
                else
                    run(ahio_proto_e'(p), 1'(d), 3'($urandom_range(7)),
                        1'($urandom), 1'($urandom));
            end
        end
        complete_run();
    end
endmodule
